// ==== core/wfd_map.svh ====
// Constants for the wake frame detector: field positions, reset values, counts.
// Assumes inclusion by core files only; definitions only.
`ifndef WFD_MAP_SVH
`define WFD_MAP_SVH

// ****************************************
// Frame layout and pattern constants
// ****************************************
`define WFD_SYNC_LEN       3'd6
`define WFD_ADDR_COPIES    5'd16
`define WFD_MASK_BITS      128
`define WFD_CRC_PRESET     16'hFFFF
`define WFD_OFFSET_W       11
`define WFD_BYTE_CNT_W     11
`define WFD_WAKE_IRQ_BIT   8
`define WFD_IRQ_W          16
`define WFD_MCAST_BIT      0
`define WFD_ALL_ONES_BYTE  8'hFF

`endif

// ==== core/wfd_pkg.sv ====
// Types shared by the wake frame detector files.
// Assumes wfd_map.svh sits in the include path.
`default_nettype none
package wfd_pkg;
	// Magic packet search states
	typedef enum logic [1:0] {
		WFD_MP_SYNC = 2'b00,   // Counting leading all-ones bytes
		WFD_MP_ADDR = 2'b01,   // Matching address copies
		WFD_MP_DONE = 2'b10    // Full sequence seen in this frame
	} wfd_mp_state_t;
endpackage : wfd_pkg
`default_nettype wire

// ==== core/wfd_crc16.sv ====
// CRC-16 byte update used by the pattern filter.
// Assumes caller holds the accumulator register; this is pure logic.
`default_nettype none
module wfd_crc16 (
	input  wire logic [15:0] crc,       // Current accumulator
	input  wire logic [7:0]  data,      // Included byte
	output logic      [15:0] next_crc   // Updated accumulator
);
	// ****************************************
	// Byte update
	// ****************************************
	logic [7:0] f; // Intermediate terms

	// Chain of intermediates, then the folded result
	always_comb begin
		f[0] = crc[15] ^ data[0];
		for (int k = 1; k < 8; k++) begin
			f[k] = crc[15-k] ^ f[k-1] ^ data[k];
		end
		next_crc[15]    = crc[7] ^ f[7];
		next_crc[14:10] = crc[6:2];
		next_crc[9]     = crc[1] ^ f[0];
		next_crc[8]     = crc[0] ^ f[1];
		for (int k = 0; k < 6; k++) begin
			next_crc[7-k] = f[k] ^ f[k+2];
		end
		next_crc[1] = f[6];
		next_crc[0] = f[7];
	end
endmodule : wfd_crc16
`default_nettype wire

// ==== core/wfd_detector.sv ====
// Wake frame detector: magic packet and pattern filter for one PHY port.
// Assumes a byte stream from the receive path with sof/byte/eof strobes and
// a frame-good verdict presented together with eof.
//
// Notes on behaviour
// - Magic packet: six FF, sixteen address copies
// - Magic match sets wake flag and magic flag
// - Byte mask selects 128 bytes from offset
// - CRC over selected bytes, match sets flag
// - CRC preset all ones each frame, selective
// - Intermediate terms chained from CRC and data
// - Next CRC formed from intermediates and shifts
// - Offset zero is first destination address byte
// - Specific, multicast, broadcast qualifiers picked by frame type
// - Wake table by frame type and enables
// - Pattern wake needs good FCS and length
// - Pattern test only while pattern wake enabled
// - Pattern match sets filter triggered bit
// - Config A holds enables and offset
// - Every wake event sets wake interrupt flag
`include "wfd_map.svh"
`default_nettype none
module wfd_detector import wfd_pkg::*; #(
	parameter int MASK_BITS = `WFD_MASK_BITS   // Byte mask width
) (
	input  wire logic                     clk,                 // 40 MHz receive clock
	input  wire logic                     reset,               // Synchronous, active high
	input  wire logic                     rx_sof,              // First byte of frame (DA byte 0) is on rx_data
	input  wire logic                     rx_valid,            // rx_data holds a frame byte
	input  wire logic [7:0]               rx_data,             // Received frame byte
	input  wire logic                     rx_eof,              // Frame ended, verdict valid
	input  wire logic                     rx_frame_good,       // FCS and length checks passed
	input  wire logic [15:0]              wake_addr_reg_a,     // Station address bytes 1:0
	input  wire logic [15:0]              wake_addr_reg_b,     // Station address bytes 3:2
	input  wire logic [15:0]              wake_addr_reg_c,     // Station address bytes 5:4
	input  wire logic                     magic_packet_enable, // Magic packet search on
	input  wire logic                     pattern_wake_enable, // Pattern wake on
	input  wire logic                     filter_enable,       // Config A: filter on
	input  wire logic                     addr_match_enable,   // Config A: specific address check
	input  wire logic                     any_mcast_enable,    // Config A: any multicast
	input  wire logic                     bcast_enable,        // Config A: broadcast
	input  wire logic [`WFD_OFFSET_W-1:0] pattern_offset,      // Config A: first checked byte
	input  wire logic [15:0]              filter_crc_reg,      // Expected CRC-16
	input  wire logic [MASK_BITS-1:0]     filter_byte_mask_regs, // Byte mask
	input  wire logic                     flag_clear,          // One-cycle clear of all sticky flags
	output logic                          magic_match_flag,    // Sticky: magic packet seen
	output logic                          pattern_frame_flag,  // Sticky: pattern frame seen
	output logic                          filter_triggered,    // Sticky: config A trigger bit
	output logic                          wake_irq_flag,       // Sticky: port irq flag bit eight
	output logic                          wake_event           // One-cycle pulse per wake frame
);
	// ****************************************
	// Frame-level state
	// ****************************************
	logic [`WFD_BYTE_CNT_W-1:0] byte_cnt, next_byte_cnt;  // Index of next byte
	logic [15:0]                crc, next_crc;            // Pattern accumulator
	logic [47:0]                da, next_da;              // Captured destination address
	wfd_mp_state_t              mp_state, next_mp_state;  // Magic search state
	logic [2:0]                 mp_pos, next_mp_pos;      // Byte within a group of six
	logic [4:0]                 mp_copy, next_mp_copy;    // Address copies matched
	logic [2:0]                 ff_run, next_ff_run;      // Running count of FF bytes
	logic [15:0]                crc_upd;                  // CRC after this byte
	logic [15:0]                crc_in;                   // Accumulator fed to the update, preset on sof
	logic [47:0]                station;                  // Station address, byte 0 low
	logic [7:0]                 exp_byte;                 // Expected address byte
	logic [`WFD_BYTE_CNT_W-1:0] idx;                      // Effective byte index
	logic [`WFD_BYTE_CNT_W-1:0] rel;                      // Index relative to offset
	logic                       sel;                      // Byte chosen by the mask
	logic                       next_magic, next_pattern, next_trig, next_irq, next_event;
	logic                       magic_hit, pattern_hit, is_bcast, is_mcast, addr_hit, qual;

	// Station address assembled with byte 0 first on the wire
	assign station = {wake_addr_reg_c, wake_addr_reg_b, wake_addr_reg_a};

	// The first byte must see the preset, not the previous frame's leftover sum
	assign crc_in = rx_sof ? `WFD_CRC_PRESET : crc;

	wfd_crc16 u_crc (
		.crc      (crc_in),
		.data     (rx_data),
		.next_crc (crc_upd)
	);

	// ****************************************
	// Per-byte tracking
	// ****************************************
	// Byte counter, CRC, DA capture and magic search
	always_comb begin
		next_byte_cnt = byte_cnt;
		next_crc      = crc;
		next_da       = da;
		next_mp_state = mp_state;
		next_mp_pos   = mp_pos;
		next_mp_copy  = mp_copy;
		next_ff_run   = ff_run;
		// sof restarts everything so offset zero is DA byte 0
		idx      = rx_sof ? '0 : byte_cnt;
		rel      = idx - pattern_offset;
		// Offset window plus mask bit decide inclusion
		sel      = (idx >= pattern_offset) && (rel < `WFD_BYTE_CNT_W'(MASK_BITS))
		         && filter_byte_mask_regs[rel[6:0]];
		exp_byte = station[8*mp_pos +: 8];
		if (rx_sof) begin
			next_crc      = `WFD_CRC_PRESET;
			next_mp_state = WFD_MP_SYNC;
			next_mp_pos   = '0;
			next_mp_copy  = '0;
			next_ff_run   = '0;
		end
		if (rx_valid) begin
			if (idx != '1) begin
				next_byte_cnt = idx + 1'b1;
			end else begin
				next_byte_cnt = idx; // Saturate on giant frames
			end
			if (sel) begin
				next_crc = crc_upd;
			end
			if (idx < 6) begin
				next_da[8*idx[2:0] +: 8] = rx_data;
			end
			// Magic search; a broken address run falls back to FF counting
			unique case (rx_sof ? WFD_MP_SYNC : mp_state)
				WFD_MP_SYNC: begin
					if (rx_data == `WFD_ALL_ONES_BYTE) begin
						next_ff_run = ((rx_sof ? 3'd0 : ff_run) == `WFD_SYNC_LEN) ? `WFD_SYNC_LEN
						            : (rx_sof ? 3'd1 : ff_run + 3'd1);
					end else if (ff_run == `WFD_SYNC_LEN && !rx_sof && rx_data == station[7:0]) begin
						next_mp_state = WFD_MP_ADDR;
						next_mp_pos   = 3'd1;
						next_mp_copy  = '0;
						next_ff_run   = '0;
					end else begin
						next_ff_run = '0;
					end
				end
				WFD_MP_ADDR: begin
					if (rx_data == exp_byte) begin
						if (mp_pos == 3'd5) begin
							next_mp_pos  = '0;
							next_mp_copy = mp_copy + 5'd1;
							if (mp_copy + 5'd1 == `WFD_ADDR_COPIES) begin
								next_mp_state = WFD_MP_DONE;
							end
						end else begin
							next_mp_pos = mp_pos + 3'd1;
						end
					end else begin
						// Restart; an FF here may begin a new sync run
						next_mp_state = WFD_MP_SYNC;
						next_ff_run   = (rx_data == `WFD_ALL_ONES_BYTE) ? 3'd1 : 3'd0;
					end
				end
				WFD_MP_DONE: begin
					next_mp_state = WFD_MP_DONE;
				end
				default: begin
					next_mp_state = WFD_MP_SYNC;
				end
			endcase
		end else if (rx_sof) begin
			next_byte_cnt = '0;
		end
	end

	// ****************************************
	// End-of-frame decision and sticky flags
	// ****************************************
	// Pattern decision uses the verdict given with eof, magic ignores it, one event per frame
	always_comb begin
		is_bcast    = (da == 48'hFFFF_FFFF_FFFF);
		is_mcast    = da[`WFD_MCAST_BIT] && !is_bcast;
		addr_hit    = (da == station);
		// Table: unicast, multicast, broadcast columns
		if (is_bcast) begin
			qual = bcast_enable;
		end else if (is_mcast) begin
			qual = any_mcast_enable || (addr_match_enable && addr_hit);
		end else begin
			qual = !addr_match_enable || addr_hit;
		end
		magic_hit   = rx_eof && magic_packet_enable && (mp_state == WFD_MP_DONE);
		pattern_hit = rx_eof && rx_frame_good && pattern_wake_enable && filter_enable
		            && (crc == filter_crc_reg) && qual;
		// Set wins over a clear in the same cycle
		next_magic   = magic_hit || (magic_match_flag && !flag_clear);
		next_pattern = pattern_hit || (pattern_frame_flag && !flag_clear);
		next_trig    = pattern_hit || (filter_triggered && !flag_clear);
		next_irq     = magic_hit || pattern_hit || (wake_irq_flag && !flag_clear);
		next_event   = magic_hit || pattern_hit;
	end

	// ****************************************
	// Registers
	// ****************************************
	// Only registering here; all decisions live above
	always_ff @(posedge clk) begin
		if (reset) begin
			byte_cnt           <= '0;
			crc                <= `WFD_CRC_PRESET;
			da                 <= '0;
			mp_state           <= WFD_MP_SYNC;
			mp_pos             <= '0;
			mp_copy            <= '0;
			ff_run             <= '0;
			magic_match_flag   <= 1'b0;
			pattern_frame_flag <= 1'b0;
			filter_triggered   <= 1'b0;
			wake_irq_flag      <= 1'b0;
			wake_event         <= 1'b0;
		end else begin
			byte_cnt           <= next_byte_cnt;
			crc                <= next_crc;
			da                 <= next_da;
			mp_state           <= next_mp_state;
			mp_pos             <= next_mp_pos;
			mp_copy            <= next_mp_copy;
			ff_run             <= next_ff_run;
			magic_match_flag   <= next_magic;
			pattern_frame_flag <= next_pattern;
			filter_triggered   <= next_trig;
			wake_irq_flag      <= next_irq;
			wake_event         <= next_event;
		end
	end
endmodule : wfd_detector
`default_nettype wire

// ==== tb/wfd_detector_asserts.sv ====
// Checker for the wake frame detector, bound onto its ports.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module wfd_detector_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic rx_eof,
	input wire logic rx_frame_good,
	input wire logic magic_packet_enable,
	input wire logic pattern_wake_enable,
	input wire logic filter_enable,
	input wire logic flag_clear,
	input wire logic magic_match_flag,
	input wire logic pattern_frame_flag,
	input wire logic filter_triggered,
	input wire logic wake_irq_flag,
	input wire logic wake_event
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// ****************************************
	// Frame end decisions
	// ****************************************
	// A clear with no frame end in the same cycle, since a set wins over a clear
	sequence s_clear; flag_clear && !rx_eof; endsequence
	// Frame ends with both wake searches off
	sequence s_off; rx_eof && !magic_packet_enable && !pattern_wake_enable; endsequence
	property p_end; wake_event |-> $past(rx_eof); endproperty
	a_end: assert property (p_end) else $error("wake pulse without frame end");
	property p_pulse; wake_event |=> !wake_event; endproperty
	a_pulse: assert property (p_pulse) else $error("wake pulse too long");
	property p_magic; $rose(magic_match_flag) |-> $past(rx_eof && magic_packet_enable); endproperty
	a_magic: assert property (p_magic) else $error("magic flag without cause");
	property p_patt; $rose(pattern_frame_flag) |-> $past(rx_eof && rx_frame_good && filter_enable); endproperty
	a_patt: assert property (p_patt) else $error("pattern flag without cause");
	property p_trig; filter_triggered == pattern_frame_flag; endproperty
	a_trig: assert property (p_trig) else $error("trigger bit apart from pattern flag");
	property p_irq; (magic_match_flag || pattern_frame_flag) |-> wake_irq_flag; endproperty
	a_irq: assert property (p_irq) else $error("wake irq flag missing");
	property p_off; s_off |=> !wake_event; endproperty
	a_off: assert property (p_off) else $error("wake while disabled");
	property p_clear;
		s_clear |=> !(wake_irq_flag || magic_match_flag || pattern_frame_flag || filter_triggered);
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared");
	property p_hold; wake_irq_flag && !flag_clear |=> wake_irq_flag; endproperty
	a_hold: assert property (p_hold) else $error("wake irq flag dropped");
endmodule : wfd_detector_asserts
`default_nettype wire

// ==== tb/wfd_rx_model.sv ====
// Receive path model: plays one frame from its byte memory per start pulse.
// Assumes the bench loads mem and holds len and good while busy.
`default_nettype none
module wfd_rx_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       start,
	input  wire logic [7:0] len,
	input  wire logic       good,
	output var  logic       rx_sof,
	output var  logic       rx_valid,
	output var  logic [7:0] rx_data,
	output var  logic       rx_eof,
	output var  logic       rx_frame_good,
	output var  logic       busy
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:255]; // Frame bytes, first destination byte at 0
	logic [7:0] idx;         // Next byte to send
	initial {rx_sof, rx_valid, rx_eof, rx_frame_good, busy, rx_data} = 13'h0000;
	// Idle data toggles and the idle verdict is the inverse of good, so a stale byte or verdict never looks live
	always @(posedge clk) begin
		{rx_sof, rx_valid, rx_eof} <= 3'h0;
		rx_data <= ~rx_data;
		rx_frame_good <= ~good;
		if (reset) begin
			busy <= 1'b0;
		end else if (start && !busy) begin
			busy <= 1'b1;
			idx <= 8'h00;
		end else if (busy && idx < len) begin
			rx_sof <= (idx == 8'h00);
			rx_valid <= 1'b1;
			rx_data <= mem[idx];
			idx <= idx + 8'h01;
		end else if (busy) begin
			rx_eof <= 1'b1;
			rx_frame_good <= good;
			busy <= 1'b0;
		end
	end
endmodule : wfd_rx_model
`default_nettype wire

// ==== tb/wfd_detector_bench.sv ====
// Bench for the wake frame detector: magic packet and pattern filter frames.
// Assumes core files, receive model and checker are compiled before it.
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
	$display("Error %s expected %0h seen %0h", nm, ex, got); end end
module wfd_detector_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, reset = 1'b1, start = 1'b0, good_r = 1'b0, flag_clear = 1'b0;
	logic magic_packet_enable = 1'b0, pattern_wake_enable = 1'b0, filter_enable = 1'b0;
	logic addr_match_enable = 1'b0, any_mcast_enable = 1'b0, bcast_enable = 1'b0;
	logic [7:0] len_r = 8'h00;
	logic [10:0] pattern_offset = 11'h000;
	logic [15:0] filter_crc_reg = 16'h0000, wake_addr_reg_a = 16'h0000, wake_addr_reg_b = 16'h0000;
	logic [15:0] wake_addr_reg_c = 16'h0000;
	logic [127:0] filter_byte_mask_regs = 128'h0;
	logic rx_sof, rx_valid, rx_eof, rx_frame_good, busy;
	logic [7:0] rx_data;
	logic magic_match_flag, pattern_frame_flag, filter_triggered, wake_irq_flag, wake_event;
	logic [7:0] sta [0:5]; // Station address, byte 0 first on the wire
	int n_fail = 0, checks_done = 0, n_wake = 0, cycles = 0;
	// Mask edges: bytes 0, 1, 3 and 127 past the offset
	localparam logic [127:0] sel_mask = {1'b1, 123'h0, 4'hB};
	wfd_rx_model u_wfd_rx_model (.clk, .reset, .start, .len(len_r), .good(good_r), .rx_sof, .rx_valid,
		.rx_data, .rx_eof, .rx_frame_good, .busy);
	wfd_detector u_wfd_detector (.clk, .reset, .rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_frame_good,
		.wake_addr_reg_a, .wake_addr_reg_b, .wake_addr_reg_c, .magic_packet_enable, .pattern_wake_enable,
		.filter_enable, .addr_match_enable, .any_mcast_enable, .bcast_enable, .pattern_offset,
		.filter_crc_reg, .filter_byte_mask_regs, .flag_clear, .magic_match_flag, .pattern_frame_flag,
		.filter_triggered, .wake_irq_flag, .wake_event);
	always #12.5 clk = ~clk;
	// Cycle ceiling and wake pulse count
	always @(posedge clk) begin
		cycles++;
		if (wake_event === 1'b1) n_wake++;
		if (cycles == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : stop_test
	// Reference CRC byte update, written independently of the core
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		logic [7:0] f;
		f[0] = c[15] ^ d[0];
		for (int k = 1; k < 8; k++) f[k] = c[15 - k] ^ f[k - 1] ^ d[k];
		return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4],
			f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
	endfunction : crc_upd
	task automatic set_sta(input logic [7:0] b0);
		sta = '{b0, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		@(posedge clk);
		wake_addr_reg_a <= {sta[1], sta[0]};
		wake_addr_reg_b <= {sta[3], sta[2]};
		wake_addr_reg_c <= {sta[5], sta[4]};
	endtask : set_sta
	// Payload fill, then destination: broadcast, station, or station with last byte off
	task automatic fill(input logic bcst, input logic hit);
		for (int i = 0; i < 256; i++) u_wfd_rx_model.mem[i] = 8'(i * 7 + 3);
		for (int i = 0; i < 6; i++) u_wfd_rx_model.mem[i] = bcst ? 8'hFF : sta[i] ^ {7'h00, i == 5 && !hit};
	endtask : fill
	// One frame with flags cleared first, then flags and pulse count judged
	task automatic send(input logic [7:0] len, input logic good, input logic ex_m, input logic ex_p);
		int n0;
		int w;
		@(posedge clk);
		{flag_clear, start, len_r, good_r} <= {2'h3, len, good};
		@(posedge clk);
		{flag_clear, start} <= 2'h0;
		n0 = n_wake;
		w = 0;
		@(posedge clk);
		#1;
		while (busy === 1'b1 && w < 400) begin
			@(posedge clk);
			#1;
			w++;
		end
		@(posedge clk);
		#1;
		`CHK("magic flag", ex_m, magic_match_flag)
		`CHK("pattern flag", ex_p, pattern_frame_flag)
		`CHK("filter triggered", ex_p, filter_triggered)
		`CHK("wake irq flag", ex_m | ex_p, wake_irq_flag)
		`CHK("wake pulse", ex_m | ex_p, wake_event)
		// The pulse counter samples on the following edge, so count after it
		@(posedge clk);
		#1;
		`CHK("wake pulse end", 1'b0, wake_event)
		`CHK("wake events", ex_m | ex_p, n_wake - n0)
	endtask : send
	// Full magic packet, last copy broken, then search switched off
	task automatic magic_tests;
		set_sta(8'h02);
		for (int c = 0; c < 3; c++) begin
			fill(1'b0, 1'b1);
			for (int i = 0; i < 102; i++) u_wfd_rx_model.mem[12 + i] = (i < 6) ? 8'hFF : sta[(i - 6) % 6];
			if (c == 1) u_wfd_rx_model.mem[113] = 8'h00;
			@(posedge clk);
			magic_packet_enable <= c != 2;
			send(8'h76, 1'b0, c == 0, 1'b0);
		end
	endtask : magic_tests
	// Wake table over frame types and qualifiers, then refusals
	task automatic pattern_tests;
		logic hit, bc, mc, am, ex;
		logic [15:0] crc;
		fill(1'b0, 1'b1);
		crc = 16'hFFFF;
		for (int j = 0; j < 128; j++) if (sel_mask[j]) crc = crc_upd(crc, u_wfd_rx_model.mem[12 + j]);
		@(posedge clk);
		pattern_offset <= 11'h00C;
		filter_byte_mask_regs <= sel_mask;
		filter_crc_reg <= crc;
		@(posedge clk);
		{magic_packet_enable, pattern_wake_enable, filter_enable} <= 3'h3;
		for (int t = 0; t < 3; t++) for (int e = 0; e < 16; e++) begin
			{hit, bc, mc, am} = 4'(e);
			set_sta(t == 1 ? 8'h03 : 8'h02);
			fill(t == 2, hit);
			@(posedge clk);
			{addr_match_enable, any_mcast_enable, bcast_enable} <= {am, mc, bc};
			ex = (t == 0) ? (!am || hit) : (t == 1) ? (mc || (am && hit)) : bc;
			send(8'h91, 1'b1, 1'b0, ex);
		end
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			filter_crc_reg <= crc ^ {15'h0000, c == 1};
			{pattern_wake_enable, filter_enable} <= {c != 2, c != 3};
			send(8'h91, c != 0, 1'b0, 1'b0);
		end
		// Offset zero: the first checked byte arrives with the start strobe
		crc = 16'hFFFF;
		for (int j = 0; j < 128; j++) if (sel_mask[j]) crc = crc_upd(crc, u_wfd_rx_model.mem[j]);
		@(posedge clk);
		pattern_offset <= 11'h000;
		filter_crc_reg <= crc;
		@(posedge clk);
		filter_enable <= 1'b1;
		send(8'h91, 1'b1, 1'b0, 1'b1);
	endtask : pattern_tests
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		`CHK("flags after reset", 5'h00, {magic_match_flag, pattern_frame_flag, filter_triggered,
			wake_irq_flag, wake_event})
		magic_tests();
		pattern_tests();
		stop_test();
	end
endmodule : wfd_detector_bench
bind wfd_detector wfd_detector_asserts u_wfd_detector_asserts (.clk, .reset, .rx_eof, .rx_frame_good,
	.magic_packet_enable, .pattern_wake_enable, .filter_enable, .flag_clear, .magic_match_flag,
	.pattern_frame_flag, .filter_triggered, .wake_irq_flag, .wake_event);
`default_nettype wire
